// ==== core/aaff_auto_ack_frame_filter.sv ====
/*
 Receive frame filter and automatic acknowledgement control with an
 AHB-Lite register slave. Assumes a header parser that presents the
 frame control field and address fields, valid while rxEnd pulses.
*/
// Added by the designer: register access over AHB-Lite.
//
// Function
// - Reserved type, accept on, filter off: frame end if clean, no match, no ack.
// - Reserved type with accept and filter on is filtered like a data frame.
// - Filtered reserved frame acknowledged only with ack request and frame end.
// - Reserved type with acceptance off is discarded silently.
// - Protection bit 7 at 0x0C, reset 0, enables frame protection when set.
// - Slotted bit 0 at 0x2C, reset 0, selects slotted acknowledgement.
// - Coordinator bit 3 at 0x2E, reset 0, marks node as PAN coordinator.
// - Ack-off bit 4 at 0x2E, reset 0, suppresses all automatic acks.
// - Version field 7:6 at 0x2E limits acknowledged frame versions; 3 allows all.
// - Ack time bit 2 at 0x17 picks 12 or 2 symbol turnaround.
// - Slotted standard timing accepts trigger no earlier than two symbols after end.
// - Reserved frame type or version rejected, per reserved and version settings.
// - Present destination PAN must equal node PAN or broadcast.
// - Short destination matches node or broadcast; extended matches node long address.
// - Beacon source PAN must equal node PAN unless node PAN is broadcast.
// - Source-only data or command accepted only for coordinator with matching PAN.
// - Ack frames and frames without any address are rejected.
// - No address match event when destination mode 0 or 1 and source mode 0.
// - Slotted ack waits for rising trigger edge; host times that edge.
// - Two symbols after frame end in slotted mode result shows wait-for-ack.
// - Ack transmission starts 16 us after the trigger edge.
// - Start delimiter enters busy receive; frame end raised, then ack sent.
// - A frame passing the filter raises the address match event.
`timescale 1ns/10ps
module aaff_auto_ack_frame_filter
   import aaff_pkg::*;
#(
   parameter int TURN_STD_COUNT = TURN_STD_CYC
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic autoAckReceiveMode,
   input wire logic rxSfd,
   input wire logic rxEnd,
   input wire logic rxCrcOk,
   input wire logic [15:0] rxFcf,
   input wire logic [15:0] rxDstPan,
   input wire logic [63:0] rxDstAddr,
   input wire logic [15:0] rxSrcPan,
   input wire logic sleepTxTrigger,
   output logic busyAutoAckReceive,
   output logic frameEndEvent,
   output logic addressMatchEvent,
   output logic ackTxStart,
   output logic [2:0] transactionResult,
   output logic frameProtectOn
);

   aaff_regs_t s_ff;
   aaff_regs_t nxt_s;

   logic [2:0] ftype;
   logic [2:0] effType;
   logic [1:0] dstMode;
   logic [1:0] srcMode;
   logic [1:0] ver;
   logic [1:0] verSel;
   logic resType;
   logic resAccept;
   logic resFilt;
   logic slotted;
   logic ackShort;
   logic coord;
   logic ackOff;
   logic dstPres;
   logic srcPres;
   logic verOk;
   logic panOk;
   logic dstOk;
   logic beaconOk;
   logic srcOnlyOk;
   logic addrMatch;
   logic bypass;
   logic drop;
   logic amiSup;
   logic feNow;
   logic amiNow;
   logic needAck;
   logic trigRise;
   logic mapped;

   function automatic logic [7:0] rd_byte(aaff_regs_t r, logic [5:0] idx);
      logic [7:0] v;
      v = 8'h00;
      if (idx >= IDX_LONG0 && idx <= IDX_LONG7) begin
         v = r.longA[{3'(idx - IDX_LONG0), 3'b000} +: 8];
      end else begin
         case (idx)
            IDX_PROT: v = r.prot;
            IDX_XB: v = r.xb;
            IDX_SHORT0: v = r.shortA[7:0];
            IDX_SHORT1: v = r.shortA[15:8];
            IDX_PAN0: v = r.pan[7:0];
            IDX_PAN1: v = r.pan[15:8];
            IDX_XA: v = r.xa;
            IDX_SEED: v = r.seed;
            IDX_STAT: begin
               v[2:0] = r.trac;
               v[STAT_BUSY] = (r.st != S_IDLE);
               v[STAT_SLOT] = (r.st == S_SLOT);
            end
            default: v = 8'h00;
         endcase
      end
      return v;
   endfunction

   // Configuration fields
   assign resAccept = s_ff.xb[BIT_RES_ACCEPT];
   assign resFilt = s_ff.xb[BIT_RES_FILT];
   assign ackShort = s_ff.xb[BIT_ACK_TIME];
   assign slotted = s_ff.xa[BIT_SLOTTED];
   assign coord = s_ff.seed[BIT_COORD];
   assign ackOff = s_ff.seed[BIT_ACK_OFF];
   assign verSel = s_ff.seed[VER_SEL_LSB +: 2];

   // Frame control decode
   assign ftype = rxFcf[2:0];
   assign resType = ftype[2];
   assign effType = resType ? FT_DATA : ftype;
   assign dstMode = rxFcf[FCF_DST_LSB +: 2];
   assign srcMode = rxFcf[FCF_SRC_LSB +: 2];
   assign ver = rxFcf[FCF_VER_LSB +: 2];
   assign dstPres = dstMode[1];
   assign srcPres = srcMode[1];

   always_comb begin
      case (verSel)
         2'h0: verOk = (ver == 2'h0);
         2'h1: verOk = (ver <= 2'h1);
         2'h2: verOk = (ver <= 2'h2);
         default: verOk = 1'b1;
      endcase
   end

   // Third level filter
   assign panOk = !dstPres || rxDstPan == s_ff.pan
      || rxDstPan == BCAST;
   assign dstOk = (dstMode == AM_SHORT) ?
      (rxDstAddr[15:0] == s_ff.shortA || rxDstAddr[15:0] == BCAST) :
      (dstMode == AM_LONG) ? (rxDstAddr == s_ff.longA) : 1'b1;
   assign beaconOk = effType != FT_BEACON || s_ff.pan == BCAST
      || rxSrcPan == s_ff.pan;
   assign srcOnlyOk = !(!dstPres && srcPres
      && (effType == FT_DATA || effType == FT_CMD))
      || (coord && rxSrcPan == s_ff.pan);
   assign addrMatch = verOk && panOk && dstOk && beaconOk && srcOnlyOk
      && effType != FT_ACK && (dstPres || srcPres);

   // Reserved type handling
   assign bypass = resType && resAccept && !resFilt;
   assign drop = resType && !resAccept;
   assign amiSup = !dstMode[1] && srcMode == 2'h0;
   assign feNow = bypass ? rxCrcOk : (!drop && addrMatch && rxCrcOk);
   assign amiNow = !bypass && !drop && addrMatch && !amiSup;
   // Ack only follows a frame end of a filtered frame
   assign needAck = !bypass && feNow && rxFcf[FCF_ACKREQ]
      && !ackOff;

   // Pin is synchronous, one flop gives the edge
   assign trigRise = sleepTxTrigger && !s_ff.trigPrev;
   assign mapped = haddr[31:8] == 24'h000000 && haddr[1:0] == 2'b00;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.fe = 1'b0;
      nxt_s.address_match_event = 1'b0;
      nxt_s.ackGo = 1'b0;
      nxt_s.trigPrev = sleepTxTrigger;
      // Register write in the data phase
      if (s_ff.dpValid && s_ff.dpWrite && s_ff.dpOk) begin
         if (s_ff.dpIdx >= IDX_LONG0 && s_ff.dpIdx <= IDX_LONG7) begin
            nxt_s.longA[{3'(s_ff.dpIdx - IDX_LONG0), 3'b000} +: 8] =
               hwdata[7:0];
         end else begin
            case (s_ff.dpIdx)
               IDX_PROT: nxt_s.prot = hwdata[7:0];
               IDX_XB: nxt_s.xb = hwdata[7:0];
               IDX_SHORT0: nxt_s.shortA[7:0] = hwdata[7:0];
               IDX_SHORT1: nxt_s.shortA[15:8] = hwdata[7:0];
               IDX_PAN0: nxt_s.pan[7:0] = hwdata[7:0];
               IDX_PAN1: nxt_s.pan[15:8] = hwdata[7:0];
               IDX_XA: nxt_s.xa = hwdata[7:0];
               IDX_SEED: nxt_s.seed = hwdata[7:0];
               default: nxt_s.prot = s_ff.prot;
            endcase
         end
      end
      // Receive and acknowledgement sequence
      case (s_ff.st)
         S_IDLE: begin
            if (autoAckReceiveMode && rxSfd) begin
               nxt_s.st = S_RX;
            end
         end
         S_RX: begin
            if (rxEnd) begin
               nxt_s.fe = feNow;
               nxt_s.address_match_event = amiNow;
               if (feNow) begin
                  nxt_s.trac = TRAC_SUCCESS;
               end
               if (needAck) begin
                  nxt_s.st = S_TURN;
                  // Slotted waits two symbols before a trigger counts
                  if (slotted || ackShort) begin
                     nxt_s.cnt = CNT_W'(TURN_SHORT_CYC - 1);
                  end else begin
                     nxt_s.cnt = CNT_W'(TURN_STD_COUNT - 1);
                  end
               end else begin
                  nxt_s.st = S_IDLE;
               end
            end
         end
         S_TURN: begin
            if (s_ff.cnt == '0) begin
               if (slotted) begin
                  nxt_s.st = S_SLOT;
                  nxt_s.trac = TRAC_WAIT_ACK;
               end else begin
                  nxt_s.st = S_IDLE;
                  nxt_s.ackGo = 1'b1;
               end
            end else begin
               nxt_s.cnt = s_ff.cnt - CNT_W'(1);
            end
         end
         S_SLOT: begin
            if (trigRise) begin
               nxt_s.st = S_TXD;
               nxt_s.cnt = CNT_W'(TRIG_DLY_CYC - 1);
            end
         end
         S_TXD: begin
            if (s_ff.cnt == '0) begin
               nxt_s.st = S_IDLE;
               nxt_s.ackGo = 1'b1;
               nxt_s.trac = TRAC_SUCCESS;
            end else begin
               nxt_s.cnt = s_ff.cnt - CNT_W'(1);
            end
         end
         default: nxt_s.st = S_IDLE;
      endcase
      // Leaving the mode abandons a pending ack and any frame not ending in the same cycle
      if (!autoAckReceiveMode) begin
         nxt_s.st = S_IDLE;
         nxt_s.ackGo = 1'b0;
      end
      // Address phase; read data uses post-write values
      nxt_s.dpValid = hsel && htrans[1] && hready;
      if (nxt_s.dpValid) begin
         nxt_s.dpWrite = hwrite;
         nxt_s.dpOk = mapped;
         nxt_s.dpIdx = haddr[7:2];
         nxt_s.rdata = 32'h00000000;
         if (!hwrite && mapped) begin
            nxt_s.rdata[7:0] = rd_byte(nxt_s, haddr[7:2]);
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         s_ff <= REGS_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_ff.rdata;
   assign busyAutoAckReceive = (s_ff.st != S_IDLE);
   assign frameEndEvent = s_ff.fe;
   assign addressMatchEvent = s_ff.address_match_event;
   assign ackTxStart = s_ff.ackGo;
   assign transactionResult = s_ff.trac;
   assign frameProtectOn = s_ff.prot[BIT_PROT];

   // Helper: length of the last finished state stay
   logic [CNT_W-1:0] runLen;
   logic [CNT_W-1:0] lastLen;
   aaff_state_t lastSt;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         runLen <= CNT_W'(1);
         lastLen <= '0;
         lastSt <= S_IDLE;
      end else if (nxt_s.st != s_ff.st) begin
         runLen <= CNT_W'(1);
         lastLen <= runLen;
         lastSt <= s_ff.st;
      end else begin
         runLen <= runLen + CNT_W'(1);
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   logic inRx;
   assign inRx = s_ff.st == S_RX && autoAckReceiveMode;

   a_bypass_no_match: assert property (
      inRx && rxEnd && bypass |=>
         !addressMatchEvent && frameEndEvent == $past(rxCrcOk)
         && !busyAutoAckReceive)
      else $error("bypassed reserved frame misreported");
   a_drop_reserved: assert property (
      inRx && rxEnd && drop |=>
         !frameEndEvent && !addressMatchEvent && !busyAutoAckReceive)
      else $error("reserved frame not discarded");
   a_ack_after_end: assert property (
      $rose(s_ff.st == S_TURN) |-> frameEndEvent && !ackOff)
      else $error("ack pending without frame end");
   a_turn_length: assert property (
      ackTxStart && lastSt == S_TURN |-> lastLen == (ackShort ?
         CNT_W'(TURN_SHORT_CYC) : CNT_W'(TURN_STD_COUNT)))
      else $error("ack turnaround length wrong");
   a_early_trigger: assert property (
      s_ff.st == S_TURN && slotted && trigRise && autoAckReceiveMode
         |=> s_ff.st != S_TXD)
      else $error("trigger taken before slot wait");
   a_wait_code: assert property (
      $rose(s_ff.st == S_SLOT) |-> transactionResult == TRAC_WAIT_ACK
         && lastLen == CNT_W'(TURN_SHORT_CYC))
      else $error("slot wait code or time wrong");
   a_trigger_delay: assert property (
      ackTxStart && lastSt == S_TXD |-> lastLen == CNT_W'(TRIG_DLY_CYC))
      else $error("ack start delay after trigger wrong");
   a_match_suppress: assert property (
      inRx && rxEnd && amiSup |=> !addressMatchEvent)
      else $error("address match on suppressed modes");
   a_sfd_busy: assert property (
      s_ff.st == S_IDLE && autoAckReceiveMode && rxSfd
         |=> busyAutoAckReceive ##0 !frameEndEvent)
      else $error("start delimiter missed");
   a_ack_off_none: assert property (
      inRx && rxEnd && ackOff |=> s_ff.st != S_TURN)
      else $error("ack scheduled while disabled");
   a_ack_frame_reject: assert property (
      inRx && rxEnd && ftype == FT_ACK |=> !addressMatchEvent
         && !frameEndEvent)
      else $error("ack frame accepted");

   c_normal_ack: cover property (ackTxStart && lastSt == S_TURN);
   c_slotted_ack: cover property (ackTxStart && lastSt == S_TXD);
   c_bypass_frame: cover property (inRx && rxEnd && bypass && rxCrcOk);
   c_match_event: cover property (addressMatchEvent && frameEndEvent);

endmodule

// ==== core/aaff_pkg.sv ====
/*
 Constants, register map and state type of the auto-ack frame filter.
 Assumes a 125 MHz clock and word-aligned AHB-Lite register access.
*/
package aaff_pkg;
   // Clock and timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int SYMBOL_NS = 16000;
   localparam int TURN_STD_SYM = 12;
   localparam int TURN_SHORT_SYM = 2;
   localparam int TRIG_DLY_NS = 16000;
   localparam int SYM_CYC = (SYMBOL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TURN_STD_CYC = TURN_STD_SYM * SYM_CYC;
   localparam int TURN_SHORT_CYC = TURN_SHORT_SYM * SYM_CYC;
   localparam int TRIG_DLY_CYC =
      (TRIG_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 16;
   // Register indices, byte address is four times the index
   localparam logic [5:0] IDX_PROT = 6'h0C;
   localparam logic [5:0] IDX_XB = 6'h17;
   localparam logic [5:0] IDX_SHORT0 = 6'h20;
   localparam logic [5:0] IDX_SHORT1 = 6'h21;
   localparam logic [5:0] IDX_PAN0 = 6'h22;
   localparam logic [5:0] IDX_PAN1 = 6'h23;
   localparam logic [5:0] IDX_LONG0 = 6'h24;
   localparam logic [5:0] IDX_LONG7 = 6'h2B;
   localparam logic [5:0] IDX_XA = 6'h2C;
   localparam logic [5:0] IDX_SEED = 6'h2E;
   localparam logic [5:0] IDX_STAT = 6'h30;
   // Field positions
   localparam int BIT_PROT = 7;
   localparam int BIT_ACK_TIME = 2;
   localparam int BIT_RES_ACCEPT = 4;
   localparam int BIT_RES_FILT = 5;
   localparam int BIT_SLOTTED = 0;
   localparam int BIT_COORD = 3;
   localparam int BIT_ACK_OFF = 4;
   localparam int VER_SEL_LSB = 6;
   localparam int STAT_BUSY = 4;
   localparam int STAT_SLOT = 5;
   localparam int FCF_ACKREQ = 5;
   localparam int FCF_DST_LSB = 10;
   localparam int FCF_VER_LSB = 12;
   localparam int FCF_SRC_LSB = 14;
   localparam logic [7:0] CFG_RST = 8'h00;
   // Frame encodings
   localparam logic [2:0] FT_BEACON = 3'h0;
   localparam logic [2:0] FT_DATA = 3'h1;
   localparam logic [2:0] FT_ACK = 3'h2;
   localparam logic [2:0] FT_CMD = 3'h3;
   localparam logic [1:0] AM_SHORT = 2'h2;
   localparam logic [1:0] AM_LONG = 2'h3;
   localparam logic [15:0] BCAST = 16'hFFFF;
   localparam logic [2:0] TRAC_SUCCESS = 3'h0;
   localparam logic [2:0] TRAC_WAIT_ACK = 3'h2;
   localparam logic [2:0] TRAC_INVALID = 3'h7;

   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_RX = 5'b00010,
      S_TURN = 5'b00100,
      S_SLOT = 5'b01000,
      S_TXD = 5'b10000
   } aaff_state_t;

   typedef struct packed {
      aaff_state_t st;
      logic [CNT_W-1:0] cnt;
      logic [7:0] prot;
      logic [7:0] xb;
      logic [7:0] xa;
      logic [7:0] seed;
      logic [15:0] shortA;
      logic [15:0] pan;
      logic [63:0] longA;
      logic [2:0] trac;
      logic fe;
      logic address_match_event;
      logic ackGo;
      logic trigPrev;
      logic dpValid;
      logic dpWrite;
      logic dpOk;
      logic [5:0] dpIdx;
      logic [31:0] rdata;
   } aaff_regs_t;

   localparam aaff_regs_t REGS_RST = '{st: S_IDLE, trac: TRAC_INVALID,
      default: '0};
endpackage

// ==== verif/aaff_node_model.sv ====
/*
 Remote node and host trigger pin model for the frame filter bench.
 Assumes the bench calls one task at a time, from its main process.
*/
`timescale 1ns/10ps
module aaff_node_model (
   input wire logic clock,
   output logic rxSfd,
   output logic rxEnd,
   output logic rxCrcOk,
   output logic [15:0] rxFcf,
   output logic [15:0] rxDstPan,
   output logic [63:0] rxDstAddr,
   output logic [15:0] rxSrcPan,
   output logic sleepTxTrigger
);
   initial begin
      rxSfd = 1'b0;
      rxEnd = 1'b0;
      rxCrcOk = 1'b0;
      rxFcf = 16'h0000;
      rxDstPan = 16'h0000;
      rxDstAddr = 64'h0;
      rxSrcPan = 16'h0000;
      sleepTxTrigger = 1'b0;
   end
   // Fields inverted outside the end cycle, so stale use shows up
   task automatic send(input logic [15:0] f, input logic [15:0] dp,
      input logic [63:0] da, input logic [15:0] sp, input logic ok);
      @(posedge clock);
      rxSfd <= 1'b1;
      @(posedge clock);
      rxSfd <= 1'b0;
      repeat (3) @(posedge clock);
      rxEnd <= 1'b1;
      rxFcf <= f;
      rxDstPan <= dp;
      rxDstAddr <= da;
      rxSrcPan <= sp;
      rxCrcOk <= ok;
      @(posedge clock);
      rxEnd <= 1'b0;
      rxFcf <= ~f;
      rxDstPan <= ~dp;
      rxDstAddr <= ~da;
      rxSrcPan <= ~sp;
      rxCrcOk <= ~ok;
   endtask
   // Host raises the trigger for three cycles at its slot
   task automatic trig();
      @(posedge clock);
      sleepTxTrigger <= 1'b1;
      repeat (3) @(posedge clock);
      sleepTxTrigger <= 1'b0;
   endtask
endmodule

// ==== verif/auto_ack_frame_filter_tb.sv ====
/*
 Self-checking bench: AHB-Lite register access and frame traffic.
 Assumes the node model drives the frame link and the trigger pin.
*/
`timescale 1ns/10ps
module auto_ack_frame_filter_tb;
   import aaff_pkg::*;
   localparam int TC = 40;
   localparam int LIMIT = 40000;
   logic clock, rst_n, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic autoAckReceiveMode, rxSfd, rxEnd, rxCrcOk, sleepTxTrigger;
   logic [15:0] rxFcf, rxDstPan, rxSrcPan;
   logic [63:0] rxDstAddr;
   logic busyAutoAckReceive, frameEndEvent, addressMatchEvent;
   logic ackTxStart, frameProtectOn;
   logic [2:0] transactionResult;
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;
   int nAck = 0;
   assign hready = hreadyout;
   aaff_auto_ack_frame_filter #(.TURN_STD_COUNT(TC)) dut_u (
      .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .autoAckReceiveMode(autoAckReceiveMode),
      .rxSfd(rxSfd), .rxEnd(rxEnd), .rxCrcOk(rxCrcOk), .rxFcf(rxFcf),
      .rxDstPan(rxDstPan), .rxDstAddr(rxDstAddr), .rxSrcPan(rxSrcPan),
      .sleepTxTrigger(sleepTxTrigger),
      .busyAutoAckReceive(busyAutoAckReceive),
      .frameEndEvent(frameEndEvent), .addressMatchEvent(addressMatchEvent),
      .ackTxStart(ackTxStart), .transactionResult(transactionResult),
      .frameProtectOn(frameProtectOn));
   aaff_node_model node_u (
      .clock(clock), .rxSfd(rxSfd), .rxEnd(rxEnd), .rxCrcOk(rxCrcOk),
      .rxFcf(rxFcf), .rxDstPan(rxDstPan), .rxDstAddr(rxDstAddr),
      .rxSrcPan(rxSrcPan), .sleepTxTrigger(sleepTxTrigger));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   always @(posedge clock) begin
      if (ackTxStart === 1'b1) nAck++;
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         final_report();
      end
   end
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         failures++;
      end
   endtask
   task automatic ahb(input logic wr, input logic [5:0] idx,
      input logic [7:0] wd, output logic [31:0] rd);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      hsize <= 3'h2;
      haddr <= {24'h0, idx, 2'b00};
      do @(posedge clock); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, wd};
      do @(posedge clock); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      logic [31:0] rd;
      ahb(1'b1, idx, d, rd);
   endtask
   task automatic rdc(input logic [5:0] idx, input logic [7:0] e);
      logic [31:0] rd;
      ahb(1'b0, idx, 8'h00, rd);
      chk($sformatf("reg %h", idx), {24'h0, e}, rd);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   function automatic logic [15:0] fc(input logic [2:0] t, input logic a,
      input logic [1:0] d, input logic [1:0] v, input logic [1:0] s);
      return {s, v, d, 4'h0, a, 2'h0, t};
   endfunction
   // Ack delay counted from the frame end event; -1 means no ack
   task automatic frm(input logic [15:0] f, input logic [15:0] dp,
      input logic [63:0] da, input logic [15:0] sp, input logic ok,
      input logic eFe, input logic eAmi, input int eAck);
      int cnt;
      int got;
      cnt = 0;
      got = -1;
      node_u.send(f, dp, da, sp, ok);
      #1;
      chk("frameEndEvent", {31'h0, eFe}, {31'h0, frameEndEvent});
      chk("addressMatchEvent", {31'h0, eAmi}, {31'h0, addressMatchEvent});
      if (eAck > 0) chk("busy", 32'h1, {31'h0, busyAutoAckReceive});
      while (busyAutoAckReceive === 1'b1 && cnt < 9000) begin
         @(posedge clock);
         #1;
         cnt++;
         if (ackTxStart === 1'b1) got = cnt;
      end
      chk("ackDelay", eAck, got);
   endtask
   task automatic done(input string nm);
      $display("test %s done", nm);
   endtask
   logic [15:0] dataF;
   logic [15:0] resF;
   logic ok;
   int n0;
   initial begin
      rst_n = 1'b0;
      hsel = 1'b0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      autoAckReceiveMode = 1'b0;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      autoAckReceiveMode <= 1'b1;
      chk("trac", 32'h7, {29'h0, transactionResult});
      chk("protect", 32'h0, {31'h0, frameProtectOn});
      rdc(IDX_PROT, 8'h00);
      rdc(IDX_XA, 8'h00);
      rdc(IDX_SEED, 8'h00);
      rdc(IDX_XB, 8'h00);
      rdc(IDX_STAT, 8'h07);
      wr(IDX_STAT, 8'hFF);
      rdc(IDX_STAT, 8'h07);
      wr(6'h3F, 8'h5A);
      rdc(6'h3F, 8'h00);
      wr(IDX_PROT, 8'h80);
      rdc(IDX_PROT, 8'h80);
      chk("protect", 32'h1, {31'h0, frameProtectOn});
      done("registers");
      // Configuration only while idle
      wr(IDX_SHORT0, 8'h34);
      wr(IDX_SHORT1, 8'h12);
      wr(IDX_PAN0, 8'hCD);
      wr(IDX_PAN1, 8'hAB);
      for (int i = 0; i < 8; i++) wr(IDX_LONG0 + 6'(i), 8'(i + 1));
      rdc(IDX_PAN1, 8'hAB);
      dataF = fc(FT_DATA, 1'b1, AM_SHORT, 2'h0, AM_SHORT);
      frm(dataF, 16'hABCD, 64'h1234, 16'hABCD, 1, 1, 1, TC);
      frm(dataF, 16'h1111, 64'h1234, 16'hABCD, 1, 0, 0, -1);
      frm(dataF, BCAST, 64'hFFFF, 16'hABCD, 1, 1, 1, TC);
      frm(dataF, 16'hABCD, 64'h4321, 16'hABCD, 1, 0, 0, -1);
      frm(fc(FT_DATA, 1, AM_LONG, 0, AM_SHORT), 16'hABCD,
         64'h0807060504030201, 16'hABCD, 1, 1, 1, TC);
      frm(fc(FT_DATA, 1, AM_LONG, 0, AM_SHORT), 16'hABCD,
         64'h0807060504030209, 16'hABCD, 1, 0, 0, -1);
      frm(fc(FT_ACK, 0, AM_SHORT, 0, 0), 16'hABCD, 64'h1234,
         16'hABCD, 1, 0, 0, -1);
      frm(fc(FT_DATA, 1, 0, 0, 0), 16'hABCD, 64'h1234,
         16'hABCD, 1, 0, 0, -1);
      frm(fc(FT_BEACON, 0, 0, 0, AM_SHORT), 16'h0, 64'h0,
         16'h2222, 1, 0, 0, -1);
      frm(fc(FT_BEACON, 0, 0, 0, AM_SHORT), 16'h0, 64'h0,
         16'hABCD, 1, 1, 1, -1);
      frm(fc(FT_CMD, 1, 0, 0, AM_SHORT), 16'h0, 64'h0,
         16'hABCD, 1, 0, 0, -1);
      wr(IDX_SEED, 8'h08);
      frm(fc(FT_CMD, 1, 0, 0, AM_SHORT), 16'h0, 64'h0,
         16'hABCD, 1, 1, 1, TC);
      frm(fc(FT_DATA, 1, 0, 0, AM_SHORT), 16'h0, 64'h0,
         16'h3333, 1, 0, 0, -1);
      done("filter");
      resF = fc(3'h4, 1'b1, AM_SHORT, 2'h0, AM_SHORT);
      frm(resF, 16'hABCD, 64'h1234, 16'hABCD, 1, 0, 0, -1);
      wr(IDX_XB, 8'h10);
      frm(resF, 16'hABCD, 64'h1234, 16'hABCD, 1, 1, 0, -1);
      frm(resF, 16'h1111, 64'h9999, 16'h1111, 1, 1, 0, -1);
      frm(resF, 16'hABCD, 64'h1234, 16'hABCD, 0, 0, 0, -1);
      wr(IDX_XB, 8'h30);
      frm(resF, 16'hABCD, 64'h1234, 16'hABCD, 1, 1, 1, TC);
      frm(resF, 16'hABCD, 64'h4321, 16'hABCD, 1, 0, 0, -1);
      frm(fc(3'h4, 0, AM_SHORT, 0, AM_SHORT), 16'hABCD, 64'h1234,
         16'hABCD, 1, 1, 1, -1);
      wr(IDX_XB, 8'h00);
      done("reserved");
      wr(IDX_SEED, 8'h18);
      frm(dataF, 16'hABCD, 64'h1234, 16'hABCD, 1, 1, 1, -1);
      for (int s = 0; s < 4; s++) begin
         wr(IDX_SEED, {s[1:0], 6'h08});
         for (int v = 0; v < 4; v++) begin
            ok = (v <= s) || (s == 3);
            frm(fc(FT_DATA, 1, AM_SHORT, v[1:0], AM_SHORT), 16'hABCD,
               64'h1234, 16'hABCD, 1, ok, ok, ok ? TC : -1);
         end
      end
      done("version");
      wr(IDX_XB, 8'h04);
      frm(dataF, 16'hABCD, 64'h1234, 16'hABCD, 1, 1, 1,
         TURN_SHORT_CYC);
      wr(IDX_XB, 8'h00);
      wr(IDX_XA, 8'h01);
      rdc(IDX_XA, 8'h01);
      n0 = nAck;
      node_u.send(dataF, 16'hABCD, 64'h1234, 16'hABCD, 1'b1);
      repeat (100) @(posedge clock);
      node_u.trig();
      repeat (TURN_SHORT_CYC) @(posedge clock);
      chk("trac", {29'h0, TRAC_WAIT_ACK}, {29'h0, transactionResult});
      rdc(IDX_STAT, 8'h32);
      chk("slotAck", n0, nAck);
      node_u.trig();
      n0 = 0;
      while (ackTxStart !== 1'b1 && n0 < 3000) begin
         @(posedge clock);
         #1;
         n0++;
      end
      // Count starts three cycles after the raising edge
      chk("trigDelay", TRIG_DLY_CYC - 2, n0);
      chk("busy", 32'h0, {31'h0, busyAutoAckReceive});
      chk("trac", {29'h0, TRAC_SUCCESS}, {29'h0, transactionResult});
      // Dropping the mode abandons a pending ack
      wr(IDX_XA, 8'h00);
      n0 = nAck;
      node_u.send(dataF, 16'hABCD, 64'h1234, 16'hABCD, 1'b1);
      autoAckReceiveMode <= 1'b0;
      node_u.send(dataF, 16'hABCD, 64'h1234, 16'hABCD, 1'b1);
      #1;
      chk("frameEndEvent", 32'h0, {31'h0, frameEndEvent});
      chk("busy", 32'h0, {31'h0, busyAutoAckReceive});
      repeat (TC + 2) @(posedge clock);
      chk("abortAck", n0, nAck);
      autoAckReceiveMode <= 1'b1;
      done("slotted");
      final_report();
   end
endmodule
